// ==== logic/fpp_pkg.sv ====
// Constants, register map and types for the flash program/protect controller.
// Assumes a 25 MHz system clock and an AXI4-Lite register port with 32-bit data.
package fpp_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   // Timing figures in nanoseconds, and derived cycle counts
   localparam int unsigned BYTE_PROGRAM_TIME_NS = 30000;
   localparam int unsigned NONVOLATILE_HOLD_TIME_NS = 5000;
   localparam int unsigned READ_RECOVERY_TIME_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   localparam int unsigned PROG_CYC = (BYTE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned NVH_CYC = (NONVOLATILE_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RCV_CYC = (READ_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W = 12;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ADDR_OFS = 8'h04;
   localparam logic [7:0] PROT_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   localparam logic [7:0] TIMER_OFS = 8'h10;
   // Control fields
   localparam int unsigned CTRL_PGM_BIT = 0;
   localparam int unsigned CTRL_ERASE_BIT = 1;
   localparam int unsigned CTRL_MASS_BIT = 2;
   localparam int unsigned CTRL_HV_BIT = 3;
   // Status fields
   localparam int unsigned STAT_REFUSED_BIT = 0;
   localparam int unsigned STAT_PROT_HIT_BIT = 1;
   localparam int unsigned STAT_ANY_PROT_BIT = 2;
   localparam int unsigned STAT_TEST_V_BIT = 3;
   localparam int unsigned STAT_TIMER_BUSY_BIT = 4;
   localparam int unsigned STAT_PROT_READ_BIT = 5;
   // Timer select codes written to the timer register
   localparam logic [1:0] TSEL_PROG = 2'h1;
   localparam logic [1:0] TSEL_NVH = 2'h2;
   localparam logic [1:0] TSEL_RCV = 2'h3;
   // Reset values and address layout
   localparam logic [7:0] PROT_RESET = 8'hff;
   localparam logic [7:0] PROT_OPEN = 8'hff;
   localparam logic [15:0] FLASH_TOP = 16'hffff;
   localparam logic [15:0] FLASH_BASE = 16'hf000;
   localparam logic [15:0] WATCHDOG_SERVICE_LOCATION = 16'hffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Bus write state
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_RESP = 3'b010,
      BUS_HOLD = 3'b100
   } fpp_bus_t;
endpackage : fpp_pkg

// ==== logic/fpp_prot_if.sv ====
// Carrier between the controller and its range comparator.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface fpp_prot_if;
   logic [7:0] prot_value;
   logic [15:0] target_addr;
   logic [15:0] start_addr;
   logic protected_hit;
   logic any_protected;
   modport ctrl (output prot_value, output target_addr, input start_addr, input protected_hit, input any_protected);
   modport cmp (input prot_value, input target_addr, output start_addr, output protected_hit, output any_protected);
endinterface : fpp_prot_if
`default_nettype wire

// ==== logic/fpp_range_cmp.sv ====
// Protected range comparator: maps protect value to a start address and checks a target.
// Assumes a 64 KB space whose flash tops out at the last address.
`timescale 1ns/1ps
`default_nettype none
module fpp_range_cmp
   import fpp_pkg::*;
(
   fpp_prot_if.cmp prot
);
   // Value selects a 64-byte granule; zero maps to the flash base, so all is protected
   always_comb begin
      if (prot.prot_value == 8'h00) begin
         prot.start_addr = FLASH_BASE;
      end else begin
         prot.start_addr = {2'b11, prot.prot_value, 6'h00};
      end
   end

   // Range runs to the top address; all ones leaves everything open
   assign prot.any_protected = (prot.prot_value != PROT_OPEN);
   assign prot.protected_hit = prot.any_protected && (prot.target_addr >= prot.start_addr)
                               && (prot.target_addr <= FLASH_TOP);
endmodule // fpp_range_cmp
`default_nettype wire

// ==== logic/fpp_ctrl.sv ====
// Flash program and protect controller with an AXI4-Lite register port.
// Assumes synchronous pin inputs and a flash macro driven by the control outputs.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl
   import fpp_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic test_entry_voltage_in,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic program_select_out,
   output logic erase_select_out,
   output logic mass_erase_out,
   output logic high_voltage_enable_out,
   output logic [15:0] target_addr_out,
   output logic monitor_entry_ok_out
);
   fpp_prot_if prot ();

   fpp_range_cmp u_cmp (
      .prot(prot.cmp)
   );

   logic pgm_q, pgm_d, ers_q, ers_d, mass_q, mass_d, hv_q, hv_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0] bpv_q, bpv_d;
   logic refused_q, refused_d, prot_read_q, prot_read_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   fpp_bus_t wst_q, wst_d;
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wdat_q, wdat_d;
   logic [3:0] wstb_q, wstb_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic do_write, do_read, ofs_ok_w, ofs_ok_r;
   logic [31:0] stat_word;

   assign prot.prot_value = bpv_q;
   assign prot.target_addr = addr_q;

   // Write channel: address and data caught in either order
   assign s_axi_awready = (wst_q == BUS_IDLE) && !aw_got_q;
   assign s_axi_wready = (wst_q == BUS_IDLE) && !w_got_q;
   assign do_write = (wst_q == BUS_IDLE) && aw_got_q && w_got_q;
   assign ofs_ok_w = (awa_q == CTRL_OFS) || (awa_q == ADDR_OFS) || (awa_q == PROT_OFS) || (awa_q == TIMER_OFS);

   always_comb begin
      wst_d = wst_q;
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      awa_d = awa_q;
      wdat_d = wdat_q;
      wstb_d = wstb_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_d = 1'b1;
         awa_d = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_d = 1'b1;
         wdat_d = s_axi_wdata;
         wstb_d = s_axi_wstrb;
      end
      unique case (wst_q)
         BUS_IDLE: begin
            if (do_write) begin
               wst_d = BUS_RESP;
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               bresp_d = ofs_ok_w ? RESP_OKAY : RESP_SLVERR;
            end
         end
         BUS_RESP: begin
            if (s_axi_bready) begin
               wst_d = BUS_IDLE;
            end
         end
         default: begin
            wst_d = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wst_q <= BUS_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awa_q <= 8'h00;
         wdat_q <= 32'h0000_0000;
         wstb_q <= 4'h0;
         bresp_q <= RESP_OKAY;
      end else begin
         wst_q <= wst_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awa_q <= awa_d;
         wdat_q <= wdat_d;
         wstb_q <= wstb_d;
         bresp_q <= bresp_d;
      end
   end

   assign s_axi_bvalid = (wst_q == BUS_RESP);
   assign s_axi_bresp = bresp_q;

   // Flash control state; protection gates every attempt at high voltage
   always_comb begin
      pgm_d = pgm_q;
      ers_d = ers_q;
      mass_d = mass_q;
      hv_d = hv_q;
      addr_d = addr_q;
      bpv_d = bpv_q;
      refused_d = refused_q;
      prot_read_d = prot_read_q;
      tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
      if (do_write && wstb_q[0]) begin
         unique case (awa_q)
            CTRL_OFS: begin
               pgm_d = wdat_q[CTRL_PGM_BIT];
               ers_d = wdat_q[CTRL_ERASE_BIT];
               mass_d = wdat_q[CTRL_MASS_BIT] && !prot.any_protected;
               if (wdat_q[CTRL_PGM_BIT] && !pgm_q || wdat_q[CTRL_ERASE_BIT] && !ers_q) begin
                  prot_read_d = 1'b0; // New operation needs a fresh protect read
               end
               if (wdat_q[CTRL_HV_BIT] && !hv_q) begin
                  // Target compared before high voltage may rise
                  if (prot.protected_hit || (wdat_q[CTRL_MASS_BIT] && prot.any_protected)) begin
                     hv_d = 1'b0;
                     refused_d = 1'b1;
                  end else begin
                     hv_d = 1'b1;
                     refused_d = 1'b0;
                  end
               end else if (!wdat_q[CTRL_HV_BIT]) begin
                  hv_d = 1'b0;
               end
            end
            ADDR_OFS: begin
               addr_d = wdat_q[15:0];
            end
            PROT_OFS: begin
               // Locked value is changed only while test entry voltage is present
               if (test_entry_voltage_in) begin
                  bpv_d = wdat_q[7:0];
               end else begin
                  refused_d = 1'b1;
               end
            end
            TIMER_OFS: begin
               unique case (wdat_q[1:0])
                  TSEL_PROG: tmr_d = TMR_W'(PROG_CYC);
                  TSEL_NVH: tmr_d = TMR_W'(NVH_CYC);
                  TSEL_RCV: tmr_d = TMR_W'(RCV_CYC);
                  default: tmr_d = '0;
               endcase
            end
            default: begin
            end
         endcase
      end
      // Protect read comes last so it wins over a select write in the same cycle
      if (do_read && (s_axi_araddr[7:2] == PROT_OFS[7:2])) begin
         prot_read_d = 1'b1; // Software checked the protect value
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pgm_q <= 1'b0;
         ers_q <= 1'b0;
         mass_q <= 1'b0;
         hv_q <= 1'b0;
         addr_q <= 16'h0000;
         bpv_q <= PROT_RESET;
         refused_q <= 1'b0;
         prot_read_q <= 1'b0;
         tmr_q <= '0;
      end else begin
         pgm_q <= pgm_d;
         ers_q <= ers_d;
         mass_q <= mass_d;
         hv_q <= hv_d;
         addr_q <= addr_d;
         bpv_q <= bpv_d;
         refused_q <= refused_d;
         prot_read_q <= prot_read_d;
         tmr_q <= tmr_d;
      end
   end

   // Read channel, one outstanding read
   assign s_axi_arready = !rvalid_q;
   assign do_read = s_axi_arvalid && !rvalid_q;
   assign ofs_ok_r = (s_axi_araddr[7:0] == CTRL_OFS) || (s_axi_araddr[7:0] == ADDR_OFS)
                     || (s_axi_araddr[7:0] == PROT_OFS) || (s_axi_araddr[7:0] == STAT_OFS)
                     || (s_axi_araddr[7:0] == TIMER_OFS);
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[STAT_REFUSED_BIT] = refused_q;
      stat_word[STAT_PROT_HIT_BIT] = prot.protected_hit;
      stat_word[STAT_ANY_PROT_BIT] = prot.any_protected;
      stat_word[STAT_TEST_V_BIT] = test_entry_voltage_in;
      stat_word[STAT_TIMER_BUSY_BIT] = (tmr_q != '0);
      stat_word[STAT_PROT_READ_BIT] = prot_read_q;
   end

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (do_read) begin
         rvalid_d = 1'b1;
         rresp_d = ofs_ok_r ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr[7:0])
            CTRL_OFS: rdata_d = {28'h0, hv_q, mass_q, ers_q, pgm_q};
            ADDR_OFS: rdata_d = {16'h0, addr_q};
            PROT_OFS: rdata_d = {24'h0, bpv_q};
            STAT_OFS: rdata_d = stat_word;
            TIMER_OFS: rdata_d = {{(32 - TMR_W){1'b0}}, tmr_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Flash macro controls straight from registers; monitor entry flag straight from the test voltage pin
   assign program_select_out = pgm_q;
   assign erase_select_out = ers_q;
   assign mass_erase_out = mass_q;
   assign high_voltage_enable_out = hv_q;
   assign target_addr_out = addr_q;
   assign monitor_entry_ok_out = test_entry_voltage_in;
endmodule // fpp_ctrl
`default_nettype wire

// ==== bench/fpp_ctrl_checker.sv ====
// Port-level assertions for the flash program/protect controller.
// Assumes one clock domain and the register port timing of the controller.
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_checker (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic test_entry_voltage_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mass_erase_out,
   input wire logic high_voltage_enable_out,
   input wire logic [15:0] target_addr_out,
   input wire logic monitor_entry_ok_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   // Write taken on both channels at once, and the answer that follows
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_resp_soon;
      ##[0:2] s_axi_bvalid;
   endsequence
   // High voltage and mass erase rise, and the target moves, only as a result of a register write; monitor flag copies the test voltage
   chk_monitor_copy: assert property (monitor_entry_ok_out == test_entry_voltage_in)
      else $error("monitor entry flag differs from test voltage");
   chk_hv_by_write: assert property ($rose(high_voltage_enable_out) |-> wr_resp_soon)
      else $error("high voltage rose without a write");
   chk_target_by_write: assert property ($changed(target_addr_out) |-> wr_resp_soon)
      else $error("target address moved without a write");
   chk_mass_by_write: assert property ($rose(mass_erase_out) |-> wr_resp_soon)
      else $error("mass erase rose without a write");
   chk_write_latency: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped early");
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address accepted with response pending");
endmodule // fpp_ctrl_checker

bind fpp_ctrl fpp_ctrl_checker u_fpp_chk (.clk_sys_in, .rst_in, .test_entry_voltage_in,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .mass_erase_out,
   .high_voltage_enable_out, .target_addr_out, .monitor_entry_ok_out);
`default_nettype wire

// ==== bench/fpp_ctrl_bench.sv ====
// Self-checking bench for the flash program/protect controller.
// Assumes the controller alone on a 25 MHz clock, driven over its register port.
`timescale 1ns/1ps
`default_nettype none
module fpp_ctrl_bench
   import fpp_pkg::*;
;
   typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] m; logic [31:0] e;} fpp_row_t;
   logic clk_sys_in = 1'h0, rst_in = 1'h1, test_entry_voltage_in = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic program_select_out, erase_select_out, mass_erase_out, high_voltage_enable_out, monitor_entry_ok_out;
   logic [15:0] target_addr_out;
   int bad_count = 0, tests_run = 0;
   time t0;
   // Write, then read back under a mask
   fpp_row_t rows [6] = '{'{ADDR_OFS, 32'hff80, ADDR_OFS, 32'hffff, 32'hff80},
      '{PROT_OFS, 32'h0, PROT_OFS, 32'hff, 32'hff}, '{ADDR_OFS, 32'hff80, STAT_OFS, 32'h5, 32'h1},
      '{CTRL_OFS, 32'h5, PROT_OFS, 32'hff, 32'hff}, '{CTRL_OFS, 32'hd, CTRL_OFS, 32'hf, 32'hd},
      '{CTRL_OFS, 32'h0, CTRL_OFS, 32'hf, 32'h0}};
   // Targets around the protect boundary of value fe, with control and expected high voltage
   logic [15:0] ta [3] = '{16'hff7f, 16'hff80, 16'hffff};
   logic [3:0] tc [3] = '{4'h9, 4'h9, 4'ha};
   logic te [3] = '{1'h1, 1'h0, 1'h0};

   fpp_ctrl DUT (.clk_sys_in, .rst_in, .test_entry_voltage_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .program_select_out, .erase_select_out, .mass_erase_out, .high_voltage_enable_out, .target_addr_out,
      .monitor_entry_ok_out);

   // Clock, 40 ns period
   initial begin
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Each channel released at its own handshake edge; slave order of aw and w is free
   // Waits for the answer however long it takes; only the watchdog ends a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic got;
      got = 1'h0;
      resp = 2'h3;
      @(posedge clk_sys_in);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!got) begin
         @(posedge clk_sys_in);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            got = 1'h1;
            resp = s_axi_bresp;
            s_axi_bready <= 1'h0;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic got;
      got = 1'h0;
      v = 32'h0;
      resp = 2'h3;
      @(posedge clk_sys_in);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!got) begin
         @(posedge clk_sys_in);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            got = 1'h1;
            v = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'h0;
         end
      end
   endtask

   // Poll the timer busy bit until the wait has run out
   task automatic wait_timer();
      logic [31:0] s;
      logic [1:0] q;
      s = 32'h0;
      s[STAT_TIMER_BUSY_BIT] = 1'h1;
      while (s[STAT_TIMER_BUSY_BIT] !== 1'h0) begin
         rd(STAT_OFS, s, q);
      end
   endtask

   // Watchdog, far beyond the eleven hundred or so cycles the tests need
   initial begin
      #(40 * 20000);
      bad_count++;
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys_in);
      rst_in <= 1'h0;
      rd(PROT_OFS, d, r);
      chk(d, {24'h0, PROT_RESET});
      chk({28'h0, program_select_out, erase_select_out, mass_erase_out, high_voltage_enable_out}, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd, r);
         chk({30'h0, r}, {30'h0, RESP_OKAY});
         rd(rows[i].ra, d, r);
         chk(d & rows[i].m, rows[i].e);
      end
      $display("test table done");
      // Byte program at f100: select, protect read, high voltage, then the program, hold and recovery waits
      wr(ADDR_OFS, 32'hf100, r);
      wr(CTRL_OFS, 32'h1, r);
      rd(PROT_OFS, d, r);
      wr(CTRL_OFS, 32'h9, r);
      chk({31'h0, high_voltage_enable_out}, 32'h1);
      t0 = $time;
      wr(TIMER_OFS, {30'h0, TSEL_PROG}, r);
      wait_timer();
      chk({31'h0, ($time - t0) >= BYTE_PROGRAM_TIME_NS}, 32'h1);
      wr(CTRL_OFS, 32'h8, r);
      chk({30'h0, program_select_out, high_voltage_enable_out}, 32'h1);
      wr(TIMER_OFS, {30'h0, TSEL_NVH}, r);
      wait_timer();
      wr(CTRL_OFS, 32'h0, r); // Watchdog location left alone while high voltage was up
      chk({31'h0, high_voltage_enable_out}, 32'h0);
      wr(TIMER_OFS, {30'h0, TSEL_RCV}, r);
      wait_timer();
      $display("test byte program done");
      // Protect from ff80 up to the top address
      test_entry_voltage_in <= 1'h1;
      wr(PROT_OFS, 32'hfe, r);
      chk({31'h0, monitor_entry_ok_out}, 32'h1);
      test_entry_voltage_in <= 1'h0;
      rd(PROT_OFS, d, r);
      chk(d, 32'hfe);
      rd(STAT_OFS, d, r);
      chk({31'h0, d[STAT_ANY_PROT_BIT]}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_OFS, {16'h0, ta[i]}, r);
         wr(CTRL_OFS, {28'h0, tc[i] & 4'h7}, r);
         rd(PROT_OFS, d, r);
         wr(CTRL_OFS, {28'h0, tc[i]}, r);
         chk({31'h0, high_voltage_enable_out}, {31'h0, te[i]});
      end
      rd(STAT_OFS, d, r);
      chk({30'h0, d[STAT_PROT_HIT_BIT], d[STAT_REFUSED_BIT]}, 32'h3);
      wr(CTRL_OFS, 32'h4, r);
      rd(CTRL_OFS, d, r);
      chk(d & 32'hf, 32'h0);
      chk({31'h0, mass_erase_out}, 32'h0);
      wr(PROT_OFS, 32'hff, r);
      rd(PROT_OFS, d, r);
      chk(d, 32'hfe);
      $display("test partial protect done");
      // All zeros locks even the array base
      test_entry_voltage_in <= 1'h1;
      wr(PROT_OFS, 32'h0, r);
      test_entry_voltage_in <= 1'h0;
      wr(ADDR_OFS, {16'h0, FLASH_BASE}, r);
      wr(CTRL_OFS, 32'h1, r);
      rd(PROT_OFS, d, r);
      chk(d, 32'h0);
      wr(CTRL_OFS, 32'h9, r);
      chk({31'h0, high_voltage_enable_out}, 32'h0);
      $display("test full protect done");
      // Unmapped place and timer
      wr(8'h20, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h20, d, r);
      chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
      wr(TIMER_OFS, {30'h0, TSEL_NVH}, r);
      rd(TIMER_OFS, d, r);
      chk({31'h0, d > 0 && d <= NVH_CYC}, 32'h1);
      $display("test unmapped and timer done");
      // Reset in mid-run brings the open protect value back
      rst_in <= 1'h1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'h0;
      rd(PROT_OFS, d, r);
      chk(d, {24'h0, PROT_RESET});
      $display("test second reset done");
      end_of_test();
   end
endmodule // fpp_ctrl_bench
`default_nettype wire
